// file: shared/gpio_params.svh
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define GP_ADDR_DATA0 8'h80
`define GP_ADDR_DATA1 8'h90
`define GP_ADDR_DATA2 8'ha0
`define GP_ADDR_DATA3 8'hb0
`define GP_ADDR_DIR0 8'he1
`define GP_ADDR_DIR1 8'he2
`define GP_ADDR_DIR2 8'he3
`define GP_ADDR_DIR3 8'he4
`define GP_ADDR_PULL0 8'he9
`define GP_ADDR_PULL1 8'hea
`define GP_ADDR_PULL2 8'heb
`define GP_ADDR_PULL3 8'hec
`define GP_ADDR_OTYPE 8'hef

// ----------------------------------------
// Implemented bits and reset values
// ----------------------------------------
`define GP_PIN_MASK 32'h3fff_fcfc
`define GP_OTYPE_MASK 8'h3c
`define GP_RESET_WORD 32'h0000_0000
`define GP_RESET_BYTE 8'h00
`define GP_PORT_COUNT 4
`define GP_PIN_COUNT 32

`endif

// file: shared/gpio_pkg.sv
package gpio_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [1:0] port_idx_t;
	typedef logic [31:0] pin_vec_t;

	typedef enum logic [4:0] {
		REG_NONE = 5'h01,
		REG_DATA = 5'h02,
		REG_DIR = 5'h04,
		REG_PULL = 5'h08,
		REG_OTYPE = 5'h10
	} reg_kind_t;

endpackage

// file: logic/gpio_pin_cell.sv
`timescale 1ns/10ps

module gpio_pin_cell (
	// Bit configuration
	input wire logic impl,
	input wire logic dir,
	input wire logic data,
	input wire logic pull,
	input wire logic open_drain,
	// Higher priority alternative function
	input wire logic hi_en,
	input wire logic hi_oe,
	input wire logic hi_out,
	input wire logic hi_pull,
	// Lower priority alternative function
	input wire logic lo_en,
	input wire logic lo_oe,
	input wire logic lo_out,
	input wire logic lo_pull,
	// Resolved pad control
	output logic oe,
	output logic out,
	output logic pull_on,
	output logic alt_own
);

	// ----------------------------------------
	// Pad resolution
	// ----------------------------------------
	always_comb begin
		oe = 1'b0;
		out = 1'b0;
		pull_on = 1'b0;
		alt_own = 1'b0;
		if (!impl) begin
			// Missing pins stay dead whatever is requested
			oe = 1'b0;
		end else if (hi_en) begin // RULE8 RULE11
			alt_own = 1'b1;
			oe = hi_oe;
			out = hi_out;
			pull_on = hi_pull;
		end else if (lo_en) begin // RULE8
			alt_own = 1'b1;
			oe = lo_oe;
			out = lo_out;
			pull_on = lo_pull;
		end else if (dir) begin // RULE1
			// Pull-up dropped while driving to save current
			pull_on = 1'b0; // RULE3
			if (open_drain) begin
				oe = ~data; // RULE12
				out = 1'b0;
			end else begin
				oe = 1'b1; // RULE5
				out = data;
			end
		end else begin
			pull_on = pull; // RULE2
		end
	end

endmodule

// file: logic/gpio_port_bank.sv
// Operation
// RULE1: Direction bit: 0 input, 1 drives data
// RULE2: Pull-up bit: 1 connects pull-high resistor
// RULE3: Pull-up only acts in input mode
// RULE4: Per-port 8-bit readable writable data register
// RULE5: Port0 pins 2-5 select open-drain or push-pull
// RULE6: Every reset clears all configuration bits
// RULE7: 26 pins implemented; other bits inert
// RULE8: Fixed priority among sharing alternative functions
// RULE9: Read gives pin; RMW output reads register
// RULE10: Writes always update the data register
// RULE11: Alternative owner masks stored settings from pin
// RULE12: Open-drain drives low on 0, floats on 1
`timescale 1ns/10ps
`include "gpio_params.svh"

module gpio_port_bank import gpio_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic RD_RMW,
	output logic [7:0] RDATA,
	// Pads
	input wire logic [31:0] PIN_IN,
	output logic [31:0] PIN_OUT,
	output logic [31:0] PIN_OE,
	output logic [31:0] PIN_PU,
	// Higher priority alternative functions
	input wire logic [31:0] ALT_HI_EN,
	input wire logic [31:0] ALT_HI_OE,
	input wire logic [31:0] ALT_HI_OUT,
	input wire logic [31:0] ALT_HI_PU,
	// Lower priority alternative functions
	input wire logic [31:0] ALT_LO_EN,
	input wire logic [31:0] ALT_LO_OE,
	input wire logic [31:0] ALT_LO_OUT,
	input wire logic [31:0] ALT_LO_PU
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	pin_vec_t data_reg;
	pin_vec_t dir_reg;
	pin_vec_t pull_reg;
	byte_t otype_reg;
	pin_vec_t pin_oe_reg;
	pin_vec_t pin_out_reg;
	pin_vec_t pin_pu_reg;
	byte_t rdata_reg;
	byte_t rdata_next;

	reg_kind_t kind;
	port_idx_t port_sel;
	byte_t port_mask;
	byte_t wmasked;
	pin_vec_t impl_vec;
	pin_vec_t od_vec;
	pin_vec_t cell_oe;
	pin_vec_t cell_out;
	pin_vec_t cell_pu;
	pin_vec_t cell_alt;

	assign impl_vec = `GP_PIN_MASK;
	// Open-drain is the safe default: a 0 bit means open-drain
	assign od_vec = {24'h00_0000, ~otype_reg & `GP_OTYPE_MASK}; // RULE5

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		kind = REG_NONE;
		port_sel = 2'h0;
		unique case (ADDR)
			`GP_ADDR_DATA0: begin
				kind = REG_DATA;
				port_sel = 2'h0;
			end
			`GP_ADDR_DATA1: begin
				kind = REG_DATA;
				port_sel = 2'h1;
			end
			`GP_ADDR_DATA2: begin
				kind = REG_DATA;
				port_sel = 2'h2;
			end
			`GP_ADDR_DATA3: begin
				kind = REG_DATA;
				port_sel = 2'h3;
			end
			`GP_ADDR_DIR0: begin
				kind = REG_DIR;
				port_sel = 2'h0;
			end
			`GP_ADDR_DIR1: begin
				kind = REG_DIR;
				port_sel = 2'h1;
			end
			`GP_ADDR_DIR2: begin
				kind = REG_DIR;
				port_sel = 2'h2;
			end
			`GP_ADDR_DIR3: begin
				kind = REG_DIR;
				port_sel = 2'h3;
			end
			`GP_ADDR_PULL0: begin
				kind = REG_PULL;
				port_sel = 2'h0;
			end
			`GP_ADDR_PULL1: begin
				kind = REG_PULL;
				port_sel = 2'h1;
			end
			`GP_ADDR_PULL2: begin
				kind = REG_PULL;
				port_sel = 2'h2;
			end
			`GP_ADDR_PULL3: begin
				kind = REG_PULL;
				port_sel = 2'h3;
			end
			`GP_ADDR_OTYPE: begin
				kind = REG_OTYPE;
				port_sel = 2'h0;
			end
			default: begin
				kind = REG_NONE;
				port_sel = 2'h0;
			end
		endcase
	end

	assign port_mask = impl_vec[port_sel*8 +: 8];
	// Missing bits never store, so they always read back zero
	assign wmasked = WDATA & port_mask; // RULE7

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			data_reg <= `GP_RESET_WORD; // RULE6
		end else if (WR && kind == REG_DATA) begin
			// Stored even while a function owns the pin
			data_reg[port_sel*8 +: 8] <= wmasked; // RULE4 RULE10
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dir_reg <= `GP_RESET_WORD; // RULE6
		end else if (WR && kind == REG_DIR) begin
			dir_reg[port_sel*8 +: 8] <= wmasked; // RULE1 RULE11
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pull_reg <= `GP_RESET_WORD; // RULE6
		end else if (WR && kind == REG_PULL) begin
			pull_reg[port_sel*8 +: 8] <= wmasked; // RULE2 RULE11
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			otype_reg <= `GP_RESET_BYTE; // RULE6
		end else if (WR && kind == REG_OTYPE) begin
			otype_reg <= WDATA & `GP_OTYPE_MASK; // RULE5
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rdata_next = `GP_RESET_BYTE;
		unique case (kind)
			REG_DATA: begin
				if (RD_RMW) begin
					rdata_next = ((data_reg[port_sel*8 +: 8] &
						dir_reg[port_sel*8 +: 8]) |
						(PIN_IN[port_sel*8 +: 8] &
						~dir_reg[port_sel*8 +: 8])) & port_mask; // RULE9
				end else begin
					rdata_next = PIN_IN[port_sel*8 +: 8] & port_mask; // RULE9
				end
			end
			REG_DIR: rdata_next = dir_reg[port_sel*8 +: 8];
			REG_PULL: rdata_next = pull_reg[port_sel*8 +: 8];
			REG_OTYPE: rdata_next = otype_reg;
			REG_NONE: rdata_next = `GP_RESET_BYTE;
		endcase
	end

	// Data are valid only in the cycle after the strobe
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= `GP_RESET_BYTE;
		end else if (RD) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= `GP_RESET_BYTE;
		end
	end

	assign RDATA = rdata_reg;

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `GP_PIN_COUNT; gi++) begin : g_pin
			gpio_pin_cell u_cell (
				.impl(impl_vec[gi]),
				.dir(dir_reg[gi]),
				.data(data_reg[gi]),
				.pull(pull_reg[gi]),
				.open_drain(od_vec[gi]),
				.hi_en(ALT_HI_EN[gi]),
				.hi_oe(ALT_HI_OE[gi]),
				.hi_out(ALT_HI_OUT[gi]),
				.hi_pull(ALT_HI_PU[gi]),
				.lo_en(ALT_LO_EN[gi]),
				.lo_oe(ALT_LO_OE[gi]),
				.lo_out(ALT_LO_OUT[gi]),
				.lo_pull(ALT_LO_PU[gi]),
				.oe(cell_oe[gi]),
				.out(cell_out[gi]),
				.pull_on(cell_pu[gi]),
				.alt_own(cell_alt[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Pad registers
	// ----------------------------------------
	// One cycle of latency buys glitch-free pad control
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_oe_reg <= `GP_RESET_WORD; // RULE6
			pin_out_reg <= `GP_RESET_WORD;
			pin_pu_reg <= `GP_RESET_WORD;
		end else begin
			pin_oe_reg <= cell_oe & impl_vec; // RULE7
			pin_out_reg <= cell_out & impl_vec;
			pin_pu_reg <= cell_pu & impl_vec;
		end
	end

	assign PIN_OE = pin_oe_reg;
	assign PIN_OUT = pin_out_reg;
	assign PIN_PU = pin_pu_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	pin_vec_t own;
	pin_vec_t alt_oe_sel;
	byte_t pin_slice;
	assign own = ~cell_alt & impl_vec;
	assign alt_oe_sel = (ALT_HI_EN & ALT_HI_OE) |
		(~ALT_HI_EN & ALT_LO_OE);
	assign pin_slice = PIN_IN[port_sel*8 +: 8];

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_data_write;
		WR && kind == REG_DATA;
	endsequence

	sequence s_pin_read;
		RD && kind == REG_DATA && !RD_RMW;
	endsequence

	sequence s_rmw_read;
		RD && kind == REG_DATA && RD_RMW;
	endsequence

	AST_INPUT_FLOATS: assert property ( // RULE1
		1'b1 |=> (PIN_OE & $past(own & ~dir_reg)) == 32'h0000_0000)
		else $error("input-mode pin is driven");

	AST_PUSH_PULL: assert property ( // RULE1
		1'b1 |=> (((PIN_OE ^ $past(dir_reg)) |
		((PIN_OUT ^ $past(data_reg)) & $past(dir_reg))) &
		$past(own & ~od_vec)) == 32'h0000_0000)
		else $error("push-pull pin does not follow data");

	AST_PULLUP_INPUT_ONLY: assert property ( // RULE3
		1'b1 |=> (PIN_PU & $past(own)) ==
		$past(own & pull_reg & ~dir_reg))
		else $error("pull-up not gated by direction");

	AST_OPEN_DRAIN: assert property ( // RULE12
		1'b1 |=> ((PIN_OE & $past(own & od_vec)) ==
		$past(own & od_vec & dir_reg & ~data_reg)) &&
		((PIN_OUT & $past(own & od_vec)) == 32'h0000_0000))
		else $error("open-drain pin misdriven");

	AST_MISSING_PINS: assert property ( // RULE7
		((PIN_OE | PIN_OUT | PIN_PU) & ~impl_vec) == 32'h0000_0000)
		else $error("unimplemented pin active");

	AST_DATA_WRITE: assert property ( // RULE10
		s_data_write |=> data_reg[$past(port_sel)*8 +: 8] ==
		$past(WDATA & port_mask))
		else $error("port data write lost");

	AST_PIN_READ: assert property ( // RULE9
		s_pin_read |=> RDATA == $past(pin_slice & port_mask))
		else $error("port read not from pin");

	AST_RMW_READ: assert property ( // RULE9
		s_rmw_read ##0 (dir_reg[port_sel*8 +: 8] == 8'hff) |=>
		RDATA == $past(data_reg[port_sel*8 +: 8] & port_mask))
		else $error("rmw read not from data register");

	AST_ALT_OWNS: assert property ( // RULE11
		1'b1 |=> (PIN_OE & $past(cell_alt)) ==
		$past(alt_oe_sel & cell_alt))
		else $error("alternative owner lost pin");

	AST_RESET_CLEAR: assert property ( // RULE6
		@(posedge CLK) disable iff (1'b0)
		(!RST_N ##1 !RST_N) |-> (data_reg | dir_reg | pull_reg |
		pin_oe_reg | pin_out_reg | pin_pu_reg) == 32'h0000_0000 &&
		otype_reg == 8'h00)
		else $error("state not cleared by reset");

	AST_OTYPE_STORE: assert property ( // RULE5
		(WR && kind == REG_OTYPE) |=> otype_reg ==
		$past(WDATA & `GP_OTYPE_MASK))
		else $error("output type write lost");

endmodule

// file: testbench/pad_board.sv
`timescale 1ns/10ps
// ----------------------------------------
// Board model for the pad wires
// ----------------------------------------
module pad_board (
	// Clock
	input wire logic clk,
	// Device pad drive
	input wire logic [31:0] oe,
	input wire logic [31:0] out,
	input wire logic [31:0] pu,
	// Board drive onto pads the device leaves free
	input wire logic [31:0] drv_en,
	input wire logic [31:0] drv_val,
	// Wire level seen by the device
	output logic [31:0] lvl
);
	logic [31:0] last_reg = 32'h0000_0000;

	// A floating pad flips every cycle, so a read of it cannot pass by luck
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (oe[i])
				lvl[i] = out[i];
			else if (drv_en[i])
				lvl[i] = drv_val[i];
			else if (pu[i])
				lvl[i] = 1'b1;
			else
				lvl[i] = ~last_reg[i];
		end
	end

	always_ff @(posedge clk) begin
		last_reg <= lvl;
	end
endmodule

// file: testbench/tb.sv
`timescale 1ns/10ps
`include "gpio_params.svh"
module tb import gpio_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	byte_t addr = 8'h00;
	byte_t wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic rd_rmw = 1'b0;
	byte_t rdata;
	pin_vec_t pin_in, pin_out, pin_oe, pin_pu;
	pin_vec_t hi_en = 32'h0, hi_oe = 32'h0, hi_out = 32'h0, hi_pu = 32'h0;
	pin_vec_t lo_en = 32'h0, lo_oe = 32'h0, lo_out = 32'h0, lo_pu = 32'h0;
	pin_vec_t drv_en = 32'h0, drv_val = 32'h0;
	int n_fail = 0;
	int n_tests = 0;
	byte_t cfg_a[9] = '{8'he1, 8'he2, 8'he3, 8'he4, 8'he9, 8'hea, 8'heb,
		8'hec, 8'hef};
	byte_t cfg_m[9] = '{8'hfc, 8'hfc, 8'hff, 8'h3f, 8'hfc, 8'hfc, 8'hff,
		8'h3f, 8'h3c};

	always #25 clk = ~clk;

	gpio_port_bank gpio_port_bank_i (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RD_RMW(rd_rmw), .RDATA(rdata),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PU(pin_pu),
		.ALT_HI_EN(hi_en), .ALT_HI_OE(hi_oe), .ALT_HI_OUT(hi_out),
		.ALT_HI_PU(hi_pu), .ALT_LO_EN(lo_en), .ALT_LO_OE(lo_oe),
		.ALT_LO_OUT(lo_out), .ALT_LO_PU(lo_pu));

	pad_board pad_board_i (.clk(clk), .oe(pin_oe), .out(pin_out),
		.pu(pin_pu), .drv_en(drv_en), .drv_val(drv_val), .lvl(pin_in));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd(input byte_t a, input logic m, input byte_t e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		rd_rmw <= m;
		@(posedge clk);
		rd_s <= 1'b0;
		rd_rmw <= 1'b0;
		#1;
		check("read data", {24'h0, rdata}, {24'h0, e});
		@(posedge clk);
	endtask

	// Pads lag the stored setting by one cycle; three leaves margin
	task automatic pads(input pin_vec_t oe, input pin_vec_t out,
		input pin_vec_t pu);
		repeat (3) @(posedge clk);
		#1;
		check("pad enable", pin_oe, oe);
		check("pad value", pin_out & oe, out);
		check("pad pull-up", pin_pu, pu);
		@(posedge clk);
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic close_out();
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		do_reset();
		for (int i = 0; i < 9; i++) begin
			rd(cfg_a[i], 1'b0, 8'h00);
			wr(cfg_a[i], 8'hff);
			rd(cfg_a[i], 1'b0, cfg_m[i]);
		end
		pads(32'h3fff_fcfc, 32'h0, 32'h0);
		wr(8'h81, 8'hff);
		rd(8'h81, 1'b0, 8'h00);
		do_reset();
		pads(32'h0, 32'h0, 32'h0);
		rd(`GP_ADDR_DIR2, 1'b0, 8'h00);
		wr(`GP_ADDR_PULL2, 8'hff);
		pads(32'h0, 32'h0, 32'h00ff_0000);
		wr(`GP_ADDR_DIR2, 8'h0f);
		pads(32'h000f_0000, 32'h0, 32'h00f0_0000);
		wr(`GP_ADDR_DATA2, 8'ha5);
		pads(32'h000f_0000, 32'h0005_0000, 32'h00f0_0000);
		rd(`GP_ADDR_DATA2, 1'b0, 8'hf5);
		do_reset();
		drv_en <= 32'h0000_00fc;
		wr(`GP_ADDR_DIR0, 8'h0c);
		wr(`GP_ADDR_PULL0, 8'h0c);
		wr(`GP_ADDR_DATA0, 8'h04);
		pads(32'h0000_0008, 32'h0, 32'h0);
		rd(`GP_ADDR_DATA0, 1'b0, 8'h00);
		rd(`GP_ADDR_DATA0, 1'b1, 8'h04);
		wr(`GP_ADDR_OTYPE, 8'h3c);
		pads(32'h0000_000c, 32'h0000_0004, 32'h0);
		drv_en <= 32'h0;
		do_reset();
		wr(`GP_ADDR_DIR2, 8'hff);
		hi_en <= 32'h0001_0000;
		hi_oe <= 32'h0001_0000;
		hi_pu <= 32'h0001_0000;
		lo_en <= 32'h0003_0000;
		lo_oe <= 32'h0003_0000;
		lo_out <= 32'h0003_0000;
		wr(`GP_ADDR_DATA2, 8'hff);
		pads(32'h00ff_0000, 32'h00fe_0000, 32'h0001_0000);
		rd(`GP_ADDR_DATA2, 1'b1, 8'hff);
		lo_oe <= 32'h0;
		lo_pu <= 32'h0002_0000;
		pads(32'h00fd_0000, 32'h00fc_0000, 32'h0003_0000);
		hi_en <= 32'h0;
		lo_en <= 32'h0;
		pads(32'h00ff_0000, 32'h00ff_0000, 32'h0);
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule
